// File: tb_vab_attr_mask.sv
// Purpose: self-checking bench for the attribute port and write mask block
// Assumes: one clock; inputs driven on the rising edge by non-blocking assignment
// Notes: merge and colour outputs are sampled two edges after stable inputs
`timescale 1ns/10ps
module tb_vab_attr_mask;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [15:0] io_addr_in = 16'h0000;
	logic [7:0] io_wdata_in = 8'h00;
	logic io_wr_in = 1'b0;
	logic io_rd_in = 1'b0;
	logic [3:0] mem_rd_in = 4'h0;
	logic [3:0] mem_wr_in = 4'h0;
	logic [31:0] latch_data_in = 32'h0;
	logic [7:0] cpu_data_in = 8'h00;
	logic [1:0] colour_sel_c45_in = 2'h0;
	logic dot_tick_in = 1'b0;
	logic [3:0] attr_value_in = 4'h0;
	logic [7:0] io_rdata_out;
	logic [31:0] mem_wdata_out;
	logic [3:0] mem_we_out;
	logic [7:0] plane_write_mask_out;
	logic [7:0] mode_ctrl_out;
	logic pixel_advance_out;
	logic [5:0] colour_addr_out;
	logic index_state_out;
	int fails = 0;
	int n_tests = 0;
	int adv_cnt = 0;
	logic [31:0] seed = 32'd76551;
	logic [31:0] r;
	logic [5:0] pal [16];
	logic [7:0] mask;
	logic [7:0] mode;
	always #12.5 clk_in = ~clk_in;
	// advance pulses counted here so bursts of ticks can be judged in one go
	always @(posedge clk_in)
		if (pixel_advance_out === 1'b1)
			adv_cnt++;
	vab_attr_mask dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .io_addr_in(io_addr_in),
		.io_wdata_in(io_wdata_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_rdata_out(io_rdata_out),
		.mem_rd_in(mem_rd_in), .mem_wr_in(mem_wr_in), .latch_data_in(latch_data_in),
		.cpu_data_in(cpu_data_in), .colour_sel_c45_in(colour_sel_c45_in), .dot_tick_in(dot_tick_in),
		.attr_value_in(attr_value_in), .mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out),
		.plane_write_mask_out(plane_write_mask_out), .mode_ctrl_out(mode_ctrl_out),
		.pixel_advance_out(pixel_advance_out), .colour_addr_out(colour_addr_out),
		.index_state_out(index_state_out));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// kept bits come from the latches, enabled planes take the fill byte
	function automatic logic [31:0] merge(input logic [7:0] m, input logic [31:0] l, input logic [7:0] c,
		input logic [3:0] s, input logic [3:0] e);
		logic [31:0] res;
		for (int p = 0; p < 4; p++)
			res[8*p +: 8] = ((e[p] ? {8{s[p]}} : c) & m) | (l[8*p +: 8] & ~m);
		return res;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one strobe cycle; read data is settled on return
	task io(input logic wr, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		io_wr_in <= wr;
		io_rd_in <= ~wr;
		io_addr_in <= a;
		io_wdata_in <= d;
		@(posedge clk_in);
		io_wr_in <= 1'b0;
		io_rd_in <= 1'b0;
		#1;
	endtask
	task attr(input logic [7:0] sel, input logic [7:0] d);
		io(1'b1, vab_pkg::PORT_ATTR_WR, sel);
		chk(index_state_out, 1);
		io(1'b1, vab_pkg::PORT_ATTR_WR, d);
		chk(index_state_out, 0);
	endtask
	task gfx(input logic [3:0] idx, input logic [7:0] d);
		io(1'b1, vab_pkg::PORT_GFX_IDX, {4'h0, idx});
		io(1'b1, vab_pkg::PORT_GFX_DATA, d);
	endtask
	task wait2;
		repeat (2) @(posedge clk_in);
		#1;
	endtask
	task wrap_up;
		$display("comparisons=%0d mismatches=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// watchdog: the whole sequence needs well under 8000 cycles
	initial
	begin
		#200000;
		fails++;
		wrap_up;
	end
	initial
	begin
		repeat (8) @(posedge clk_in);
		arst_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		#1;
		chk(plane_write_mask_out, vab_pkg::MASK_RESET);
		chk(mode_ctrl_out, vab_pkg::MODE_RESET);
		chk(index_state_out, 0);
		// palette loaded while no dot ticks run, standing in for retrace
		for (int i = 0; i < 16; i++)
		begin
			r = rnd();
			pal[i] = r[5:0];
			attr({3'h0, i[4:0]}, {2'h0, pal[i]});
		end
		// one palette entry read back through the data phase
		io(1'b1, vab_pkg::PORT_ATTR_WR, 8'h05);
		io(1'b0, vab_pkg::PORT_ATTR_RD, 8'h00);
		chk(io_rdata_out, {2'h0, pal[5]});
		io(1'b0, vab_pkg::PORT_STATUS, 8'h00);
		chk(index_state_out, 0);
		// both colour address sources, with random mode bits below bit 7
		for (int k = 0; k < 2; k++)
		begin
			r = rnd();
			mode = {k[0], r[6:0]};
			attr({2'h0, 1'b1, vab_pkg::SEL_MODE}, mode);
			chk(mode_ctrl_out, mode & 8'hEF);
			io(1'b0, vab_pkg::PORT_ATTR_RD, 8'h00);
			chk(io_rdata_out, 8'h30);
			io(1'b1, vab_pkg::PORT_ATTR_WR, 8'h30);
			io(1'b0, vab_pkg::PORT_ATTR_RD, 8'h00);
			chk(io_rdata_out, mode & 8'hEF);
			io(1'b0, vab_pkg::PORT_STATUS, 8'h00);
			chk(index_state_out, 0);
			for (int i = 0; i < 16; i++)
			begin
				@(posedge clk_in);
				r = rnd();
				attr_value_in <= i[3:0];
				colour_sel_c45_in <= r[1:0];
				wait2;
				chk(colour_addr_out, {k[0] ? colour_sel_c45_in : pal[i][5:4], pal[i][3:0]});
			end
		end
		io(1'b0, 16'h03C2, 8'h00);
		chk(io_rdata_out, 8'h00);
		// masks with both extremes first, then random fills and latches
		for (int j = 0; j < 12; j++)
		begin
			r = rnd();
			mask = (j == 0) ? 8'h00 : (j == 1) ? 8'hFF : r[7:0];
			gfx(vab_pkg::GFX_IDX_MASK, mask);
			chk(plane_write_mask_out, mask);
			io(1'b0, vab_pkg::PORT_GFX_DATA, 8'h00);
			chk(io_rdata_out, mask);
			gfx(vab_pkg::GFX_IDX_SR, {4'h0, r[11:8]});
			gfx(vab_pkg::GFX_IDX_ESR, {4'h0, r[15:12]});
			io(1'b0, vab_pkg::PORT_GFX_IDX, 8'h00);
			chk(io_rdata_out, {4'h0, vab_pkg::GFX_IDX_ESR});
			io(1'b0, vab_pkg::PORT_GFX_DATA, 8'h00);
			chk(io_rdata_out, {4'h0, r[15:12]});
			@(posedge clk_in);
			mem_rd_in <= r[19:16];
			mem_wr_in <= r[23:20];
			cpu_data_in <= r[31:24];
			latch_data_in <= rnd();
			wait2;
			chk(mem_wdata_out, merge(mask, latch_data_in, cpu_data_in, r[11:8], r[15:12]));
			chk(mem_we_out, mem_wr_in);
		end
		// narrow then wide pixels over sixteen dot ticks
		for (int k = 0; k < 2; k++)
		begin
			attr(8'h10, k[0] ? 8'h40 : 8'h00);
			adv_cnt = 0;
			repeat (16)
			begin
				@(posedge clk_in);
				dot_tick_in <= 1'b1;
				@(posedge clk_in);
				dot_tick_in <= 1'b0;
			end
			repeat (3) @(posedge clk_in);
			#1;
			chk(adv_cnt, k[0] ? 8 : 16);
		end
		wrap_up;
	end
endmodule

// File: vab_attr_mask.sv
// Purpose: attribute index/data port, palette, mode control, and plane write mask
// Assumes: one I/O access per strobe cycle; memory latches outside, write data merge inside
// Notes: selector 10h is mode control; registers above it are not decoded and read as zero
`timescale 1ns/10ps
module vab_attr_mask
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [15:0] io_addr_in,
	input wire logic [7:0] io_wdata_in,
	input wire logic io_wr_in,
	input wire logic io_rd_in,
	output logic [7:0] io_rdata_out,
	input wire logic [3:0] mem_rd_in,
	input wire logic [3:0] mem_wr_in,
	input wire logic [31:0] latch_data_in,
	input wire logic [7:0] cpu_data_in,
	input wire logic [1:0] colour_sel_c45_in,
	input wire logic dot_tick_in,
	input wire logic [3:0] attr_value_in,
	output logic [31:0] mem_wdata_out,
	output logic [3:0] mem_we_out,
	output logic [7:0] plane_write_mask_out,
	output logic [7:0] mode_ctrl_out,
	output logic pixel_advance_out,
	output logic [5:0] colour_addr_out,
	output logic index_state_out
);
	logic rst_s1_r;
	logic rst_n_r;
	logic [7:0] plane_write_mask_r;
	logic [3:0] fill_value_r;
	logic [3:0] fill_plane_enable_r;
	logic [3:0] gfx_index_r;
	logic [4:0] attr_selector_r;
	logic palette_access_flag_r;
	logic [7:0] mode_r;
	logic [5:0] palette_r [vab_pkg::PAL_COUNT];
	logic data_phase_r;
	logic [7:0] rdata_r;
	logic [31:0] wdata_r;
	logic [3:0] we_r;
	logic half_r;
	logic adv_r;
	logic [5:0] caddr_r;
	logic last_valid_r;

	// reset release through two flops
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// port decode
	wire wr_attr = io_wr_in && io_addr_in == vab_pkg::PORT_ATTR_WR;
	wire rd_attr = io_rd_in && io_addr_in == vab_pkg::PORT_ATTR_RD;
	wire rd_status = io_rd_in && io_addr_in == vab_pkg::PORT_STATUS;
	wire wr_gidx = io_wr_in && io_addr_in == vab_pkg::PORT_GFX_IDX;
	wire wr_gdat = io_wr_in && io_addr_in == vab_pkg::PORT_GFX_DATA;
	wire rd_gidx = io_rd_in && io_addr_in == vab_pkg::PORT_GFX_IDX;
	wire rd_gdat = io_rd_in && io_addr_in == vab_pkg::PORT_GFX_DATA;
	wire wr_index = wr_attr && !data_phase_r;
	wire wr_data = wr_attr && data_phase_r;
	wire sel_pal = attr_selector_r < vab_pkg::SEL_MODE;
	wire sel_mode = attr_selector_r == vab_pkg::SEL_MODE;
	wire [3:0] pal_idx = attr_selector_r[3:0];
	wire [7:0] index_view = {2'b00, palette_access_flag_r, attr_selector_r};
	// unimplemented selectors up to 15h and reserved ones read as zero
	wire [7:0] data_view = sel_pal ? {2'b00, palette_r[pal_idx]} : (sel_mode ? mode_r : 8'h00);
	wire [7:0] gdat_view = (gfx_index_r == vab_pkg::GFX_IDX_MASK) ? plane_write_mask_r :
		(gfx_index_r == vab_pkg::GFX_IDX_SR) ? {4'h0, fill_value_r} :
		(gfx_index_r == vab_pkg::GFX_IDX_ESR) ? {4'h0, fill_plane_enable_r} : 8'h00;
	wire [7:0] rd_mux = rd_attr ? (data_phase_r ? data_view : index_view) :
		rd_gidx ? {4'h0, gfx_index_r} : rd_gdat ? gdat_view : 8'h00;

	// index/data flip-flop: status read wins over a same-cycle write
	wire phase_nxt = rd_status ? 1'b0 : (wr_attr ? !data_phase_r : data_phase_r);

	always_ff @(posedge clk_in or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			data_phase_r <= 1'b0;
			attr_selector_r <= 5'h00;
			palette_access_flag_r <= 1'b0;
			mode_r <= vab_pkg::MODE_RESET;
			rdata_r <= 8'h00;
			gfx_index_r <= 4'h0;
		end
		else
		begin
			data_phase_r <= phase_nxt;
			rdata_r <= rd_mux;
			if (wr_index)
			begin
				attr_selector_r <= io_wdata_in[4:0];
				palette_access_flag_r <= io_wdata_in[vab_pkg::IDX_BIT_PAS];
			end
			if (wr_data && sel_mode)
				mode_r <= {io_wdata_in[7:5], 1'b0, io_wdata_in[3:0]};
			if (wr_gidx)
				gfx_index_r <= io_wdata_in[3:0];
		end
	end

	// palette entries, one per generate step
	for (genvar i = 0; i < vab_pkg::PAL_COUNT; i++)
	begin : g_pal
		always_ff @(posedge clk_in or negedge rst_n_r)
		begin
			if (!rst_n_r)
				palette_r[i] <= vab_pkg::PAL_RESET;
			else if (wr_data && sel_pal && pal_idx == 4'(i))
				palette_r[i] <= io_wdata_in[5:0];
		end
	end

	// graphics mask and set/reset settings
	always_ff @(posedge clk_in or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			plane_write_mask_r <= vab_pkg::MASK_RESET;
			fill_value_r <= vab_pkg::SR_RESET;
			fill_plane_enable_r <= vab_pkg::SR_RESET;
		end
		else if (wr_gdat)
		begin
			if (gfx_index_r == vab_pkg::GFX_IDX_MASK)
				plane_write_mask_r <= io_wdata_in;
			if (gfx_index_r == vab_pkg::GFX_IDX_SR)
				fill_value_r <= io_wdata_in[3:0];
			if (gfx_index_r == vab_pkg::GFX_IDX_ESR)
				fill_plane_enable_r <= io_wdata_in[3:0];
		end
	end

	// per-plane merge; masked bits come from the latches of the last read
	wire [31:0] merged;
	for (genvar p = 0; p < 4; p++)
	begin : g_plane
		wire [7:0] newb = fill_plane_enable_r[p] ? {8{fill_value_r[p]}} : cpu_data_in;
		assign merged[p*8 +: 8] = (newb & plane_write_mask_r) |
			(latch_data_in[p*8 +: 8] & ~plane_write_mask_r);
	end

	// write path and read tracking; masking holds with or without a read, last_valid_r gates nothing
	always_ff @(posedge clk_in or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			wdata_r <= 32'h0000_0000;
			we_r <= 4'h0;
			last_valid_r <= 1'b0;
		end
		else
		begin
			wdata_r <= merged;
			we_r <= mem_wr_in;
			if (|mem_rd_in)
				last_valid_r <= 1'b1;
		end
	end

	// display-side helpers: pixel rate and colour address bits
	wire [5:0] pal_ent = palette_r[attr_value_in];
	wire [1:0] hi_bits = mode_r[vab_pkg::MODE_BIT_SRC] ? colour_sel_c45_in :
		pal_ent[vab_pkg::PAL_BIT_SB:vab_pkg::PAL_BIT_SA];
	wire adv_nxt = dot_tick_in && (!mode_r[vab_pkg::MODE_BIT_PW] || half_r);

	always_ff @(posedge clk_in or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			half_r <= 1'b0;
			adv_r <= 1'b0;
			caddr_r <= 6'h00;
		end
		else
		begin
			if (dot_tick_in)
				half_r <= !half_r;
			adv_r <= adv_nxt;
			caddr_r <= {hi_bits, pal_ent[3:0]};
		end
	end

	assign io_rdata_out = rdata_r;
	assign mem_wdata_out = wdata_r;
	assign mem_we_out = we_r;
	assign plane_write_mask_out = plane_write_mask_r;
	assign mode_ctrl_out = mode_r;
	assign pixel_advance_out = adv_r;
	assign colour_addr_out = caddr_r;
	assign index_state_out = data_phase_r;

	a_phase_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_r)
		(wr_attr && !rd_status) |=> data_phase_r != $past(data_phase_r))
		else $error("attribute phase did not toggle");
	a_status_resets: assert property (@(posedge clk_in) disable iff (!rst_n_r)
		rd_status |=> !data_phase_r)
		else $error("status read left data phase");
	a_mask_write: assert property (@(posedge clk_in) disable iff (!rst_n_r)
		(wr_gdat && gfx_index_r == vab_pkg::GFX_IDX_MASK) |=> plane_write_mask_r == $past(io_wdata_in))
		else $error("mask not loaded");
	a_mask_keep: assert property (@(posedge clk_in) disable iff (!rst_n_r)
		1'b1 |=> ((wdata_r[7:0] ^ $past(latch_data_in[7:0])) & ~$past(plane_write_mask_r)) == 8'h00)
		else $error("masked bit changed");
	a_fill_value: assert property (@(posedge clk_in) disable iff (!rst_n_r)
		(fill_plane_enable_r[0] && fill_value_r[0] && !wr_gdat) |=>
		(wdata_r[7:0] & $past(plane_write_mask_r)) == $past(plane_write_mask_r))
		else $error("fill ignored");
	a_index_read: assert property (@(posedge clk_in) disable iff (!rst_n_r)
		(rd_attr && !data_phase_r) |=> io_rdata_out == {2'b00, $past(palette_access_flag_r), $past(attr_selector_r)})
		else $error("index readback wrong");
	a_mode_reserved: assert property (@(posedge clk_in) disable iff (!rst_n_r)
		mode_ctrl_out[4] == 1'b0)
		else $error("mode reserved bit set");
	a_pixel_half: assert property (@(posedge clk_in) disable iff (!rst_n_r)
		(adv_nxt && mode_r[vab_pkg::MODE_BIT_PW]) |=> !adv_nxt)
		else $error("pixel advanced every dot in wide mode");
	a_colour_src: assert property (@(posedge clk_in) disable iff (!rst_n_r)
		mode_r[vab_pkg::MODE_BIT_SRC] |=> (colour_addr_out[5:4] == $past(colour_sel_c45_in) || $changed(mode_r)))
		else $error("colour bits not from select");
endmodule

// File: vab_pkg.sv
// Purpose: constants for the attribute port and write mask block
// Assumes: byte-wide I/O port decode, one clock domain
// Notes: port addresses are the 16-bit I/O addresses
package vab_pkg;
	localparam logic [15:0] PORT_ATTR_WR = 16'h03C0;
	localparam logic [15:0] PORT_ATTR_RD = 16'h03C1;
	localparam logic [15:0] PORT_GFX_IDX = 16'h03CE;
	localparam logic [15:0] PORT_GFX_DATA = 16'h03CF;
	localparam logic [15:0] PORT_STATUS = 16'h03DA;
	localparam logic [3:0] GFX_IDX_SR = 4'h0;
	localparam logic [3:0] GFX_IDX_ESR = 4'h1;
	localparam logic [3:0] GFX_IDX_MASK = 4'h8;
	localparam logic [4:0] SEL_MODE = 5'h10;
	localparam logic [4:0] SEL_LAST = 5'h15;
	localparam int PAL_COUNT = 16;
	localparam int PAL_BIT_SA = 4;
	localparam int PAL_BIT_SB = 5;
	localparam int MODE_BIT_SRC = 7;
	localparam int MODE_BIT_PW = 6;
	localparam int IDX_BIT_PAS = 5;
	localparam logic [7:0] MASK_RESET = 8'hFF;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [5:0] PAL_RESET = 6'h00;
	localparam logic [3:0] SR_RESET = 4'h0;
endpackage
